/* hw/mtc_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  MAC timer control registers.
  Assumes it is included by bare name wherever these names are needed.
*/
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH

`define MTC_ADDR_VALUE_LOW   8'hA6
`define MTC_ADDR_VALUE_HIGH  8'hA7
`define MTC_ADDR_CONFIG      8'hC3

`define MTC_BIT_CMP_FLAG     7
`define MTC_BIT_PER_FLAG     6
`define MTC_BIT_OFC_FLAG     5
`define MTC_BIT_UNUSED       4
`define MTC_BIT_CMP_SEL      3
`define MTC_BIT_RESERVED     2
`define MTC_BIT_SYNC         1
`define MTC_BIT_RUN          0

`define MTC_CONFIG_RESET     8'h02
`define MTC_SYNC_RESET       1'b1
`define MTC_BYTE_ZERO        8'h00
`define MTC_WORD_ZERO        16'h0000
`define MTC_WORD_ONE         16'h0001
`define MTC_WORD_MAX         16'hFFFF
`define MTC_SYNC_START_CYCLES 7'd75
`define MTC_CNT_ZERO         7'd0
`define MTC_CNT_ONE          7'd1

`endif

/* hw/mtc_pkg.sv */
/*
  Types of the MAC timer control registers: bus request, timer states and
  the packed state record of the control block.
  Assumes the register header is compiled alongside it.
*/
package mtc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] wrData;
  } mtc_sfr_req_t;

  typedef enum logic [4:0] {
    MTC_IDLE       = 5'b00001,
    MTC_WAIT_START = 5'b00010,
    MTC_STARTING   = 5'b00100,
    MTC_RUN        = 5'b01000,
    MTC_WAIT_STOP  = 5'b10000
  } mtc_state_t;

  typedef struct packed {
    mtc_state_t  state;
    logic        compareEventFlag;
    logic        periodEventFlag;
    logic        overflowCountCompareFlag;
    logic        compareByteSelect;
    logic        reservedBit;
    logic        syncSelect;
    logic [15:0] timerCount;
    logic [15:0] deltaCount;
    logic [7:0]  deltaLow;
    logic [7:0]  latchedHigh;
    logic [6:0]  startCount;
    logic [7:0]  rdData;
    logic [2:0]  irqReq;
    logic        sleepStore;
    logic        running;
  } mtc_ctrl_t;

endpackage

/* hw/mtc_edge_sync.sv */
/*
  Brings the 32.768 kHz reference into the system clock domain and emits a
  one-cycle pulse on each of its rising edges.
  Assumes the reference is slow compared with core_clk.
*/
`timescale 1ns/1ps
module mtc_edge_sync
  import mtc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic slowClk,
  output logic      risePulse
);

  logic syncA_r;
  logic syncB_r;
  logic syncC_r;

  // The first stage feeds only the second one; the edge is seen on later stages.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      syncA_r   <= 1'b0;
      syncB_r   <= 1'b0;
      syncC_r   <= 1'b0;
      risePulse <= 1'b0;
    end else begin
      syncA_r   <= slowClk;
      syncB_r   <= syncA_r;
      syncC_r   <= syncB_r;
      risePulse <= syncB_r & ~syncC_r; // see [RQ19]
    end
  end

endmodule // mtc_edge_sync

/* hw/mac_timer_control_regs.sv */
/*
  Control and value-access registers of the 16-bit MAC timer: configuration
  register with event flags, compare byte select, sync select and run bit,
  latched value reads and delta or direct-load writes.
  Assumes a single-cycle SFR access port synchronous to core_clk, event
  pulses and reload values from the surrounding timer, and a free running
  32.768 kHz reference.
*/
`timescale 1ns/1ps
`include "mtc_regs.svh"

// Summary of operation
// [RQ1] Compare event sets bit 7 flag; writing 0 clears, writing 1 ignored.
// [RQ2] Period event sets bit 6 flag; only a written 0 clears it.
// [RQ3] Overflow-count compare sets bit 5 flag; only a written 0 clears.
// [RQ4] Configuration bit 4 is unused and always reads zero.
// [RQ5] Software always writes zero to reserved bit 2.
// [RQ6] Bit 3 selects compare against timer high byte (0) or low byte (1).
// [RQ7] Sync bit 1 resets to 1; 0 immediate, 1 aligned to 32 kHz edge.
// [RQ8] Writing bit 0 as 1 requests start, as 0 requests stop.
// [RQ9] Reading bit 0 returns real state: 0 idle, 1 running.
// [RQ10] In sync mode the read status changes only at the aligned event.
// [RQ11] Low byte read returns bits 7:0 and latches high byte for later read.
// [RQ12] While running, low then high writes form a delta applied on high write.
// [RQ13] After a delta is applied the timer pauses for delta cycles.
// [RQ14] While idle, value byte writes load the timer bytes directly.
// [RQ15] Delta counter counts down at timer rate, then rests at zero.
// [RQ16] Sync stop keeps counting to the 32 kHz edge, then stores sleep time.
// [RQ17] Sync start waits for the edge, then loads new values within 75 cycles.
// [RQ18] Flags set regardless of masks; requests raised only when masked in.
// [RQ19] The 32 kHz rising edge becomes a one-cycle pulse in this domain.
module mac_timer_control_regs
  import mtc_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire mtc_sfr_req_t sfrReq,
  input  wire logic [7:0]   compareValue,
  input  wire logic [15:0]  periodValue,
  input  wire logic         overflowCompareEvent,
  input  wire logic [2:0]   irqMask,
  input  wire logic [15:0]  reloadValue,
  input  wire logic         slowClk,
  output logic [7:0]        sfrRdData,
  output logic [15:0]       timerValue,
  output logic              timerRunning,
  output logic [2:0]        irqRequest,
  output logic              sleepStoreStrobe
);

  mtc_ctrl_t  ctrl_r;
  mtc_ctrl_t  ctrl_nxt;
  logic       edgePulse;
  logic       wrConfig;
  logic       wrLow;
  logic       wrHigh;
  logic       rdConfig;
  logic       rdLow;
  logic       rdHigh;
  logic       counting;
  logic       compareHit;
  logic       periodHit;
  logic [15:0] wrapValue;
  logic [7:0] configRead;

  mtc_edge_sync u_edge (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .slowClk   (slowClk),
    .risePulse (edgePulse)
  );

  assign wrConfig = sfrReq.wrEn && (sfrReq.addr == `MTC_ADDR_CONFIG);
  assign wrLow    = sfrReq.wrEn && (sfrReq.addr == `MTC_ADDR_VALUE_LOW);
  assign wrHigh   = sfrReq.wrEn && (sfrReq.addr == `MTC_ADDR_VALUE_HIGH);
  assign rdConfig = sfrReq.rdEn && (sfrReq.addr == `MTC_ADDR_CONFIG);
  assign rdLow    = sfrReq.rdEn && (sfrReq.addr == `MTC_ADDR_VALUE_LOW);
  assign rdHigh   = sfrReq.rdEn && (sfrReq.addr == `MTC_ADDR_VALUE_HIGH);

  // The timer counts in RUN and during a pending synchronized stop.
  assign counting = ctrl_r.running && (ctrl_r.deltaCount == `MTC_WORD_ZERO); // see [RQ13]

  // A period of zero gives the longest period, a wrap at full scale.
  assign wrapValue = (periodValue == `MTC_WORD_ZERO) ? `MTC_WORD_MAX : periodValue;
  assign periodHit = counting && (ctrl_r.timerCount == wrapValue);

  always_comb begin
    if (ctrl_r.compareByteSelect) begin
      compareHit = counting && (ctrl_r.timerCount[7:0] == compareValue); // see [RQ6]
    end else begin
      compareHit = counting && (ctrl_r.timerCount[15:8] == compareValue); // see [RQ6]
    end
  end

  always_comb begin
    configRead = `MTC_BYTE_ZERO;
    configRead[`MTC_BIT_CMP_FLAG] = ctrl_r.compareEventFlag;
    configRead[`MTC_BIT_PER_FLAG] = ctrl_r.periodEventFlag;
    configRead[`MTC_BIT_OFC_FLAG] = ctrl_r.overflowCountCompareFlag;
    configRead[`MTC_BIT_UNUSED]   = 1'b0; // see [RQ4]
    configRead[`MTC_BIT_CMP_SEL]  = ctrl_r.compareByteSelect;
    configRead[`MTC_BIT_RESERVED] = ctrl_r.reservedBit;
    configRead[`MTC_BIT_SYNC]     = ctrl_r.syncSelect;
    configRead[`MTC_BIT_RUN]      = ctrl_r.running; // see [RQ9]
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    ctrl_nxt.sleepStore = 1'b0;

    // Register read path, answered one cycle after the strobe.
    if (rdConfig) begin
      ctrl_nxt.rdData = configRead;
    end else if (rdLow) begin
      ctrl_nxt.rdData      = ctrl_r.timerCount[7:0]; // see [RQ11]
      ctrl_nxt.latchedHigh = ctrl_r.timerCount[15:8]; // see [RQ11]
    end else if (rdHigh) begin
      ctrl_nxt.rdData = ctrl_r.latchedHigh; // see [RQ11]
    end else begin
      ctrl_nxt.rdData = `MTC_BYTE_ZERO;
    end

    // Configuration fields; flags take a written 0 as a clear only.
    if (wrConfig) begin
      if (!sfrReq.wrData[`MTC_BIT_CMP_FLAG]) begin
        ctrl_nxt.compareEventFlag = 1'b0; // see [RQ1]
      end
      if (!sfrReq.wrData[`MTC_BIT_PER_FLAG]) begin
        ctrl_nxt.periodEventFlag = 1'b0; // see [RQ2]
      end
      if (!sfrReq.wrData[`MTC_BIT_OFC_FLAG]) begin
        ctrl_nxt.overflowCountCompareFlag = 1'b0; // see [RQ3]
      end
      ctrl_nxt.compareByteSelect = sfrReq.wrData[`MTC_BIT_CMP_SEL];
      ctrl_nxt.reservedBit       = sfrReq.wrData[`MTC_BIT_RESERVED]; // see [RQ5]
      ctrl_nxt.syncSelect        = sfrReq.wrData[`MTC_BIT_SYNC];
    end

    // Events are applied after the clear so that a set wins.
    if (compareHit) begin
      ctrl_nxt.compareEventFlag = 1'b1; // see [RQ1]
    end
    if (periodHit) begin
      ctrl_nxt.periodEventFlag = 1'b1; // see [RQ2]
    end
    if (overflowCompareEvent) begin
      ctrl_nxt.overflowCountCompareFlag = 1'b1; // see [RQ3]
    end

    // Flags ignore the masks; requests pass only where masked in.
    ctrl_nxt.irqReq = {ctrl_nxt.compareEventFlag, ctrl_nxt.periodEventFlag,
                       ctrl_nxt.overflowCountCompareFlag} & irqMask; // see [RQ18]

    // Timer count, paused while a delta is pending.
    if (ctrl_r.running) begin
      if (ctrl_r.deltaCount != `MTC_WORD_ZERO) begin
        ctrl_nxt.deltaCount = ctrl_r.deltaCount - `MTC_WORD_ONE; // see [RQ15]
      end else if (periodHit) begin
        ctrl_nxt.timerCount = `MTC_WORD_ZERO;
      end else begin
        ctrl_nxt.timerCount = ctrl_r.timerCount + `MTC_WORD_ONE;
      end
    end

    // Value byte writes: a delta while running, a direct load otherwise.
    if (ctrl_r.running) begin
      if (wrLow) begin
        ctrl_nxt.deltaLow = sfrReq.wrData; // see [RQ12]
      end
      if (wrHigh) begin
        ctrl_nxt.deltaCount = {sfrReq.wrData, ctrl_r.deltaLow}; // see [RQ12]
      end
    end else begin
      if (wrLow) begin
        ctrl_nxt.timerCount[7:0] = sfrReq.wrData; // see [RQ14]
      end
      if (wrHigh) begin
        ctrl_nxt.timerCount[15:8] = sfrReq.wrData; // see [RQ14]
      end
    end

    // Start and stop sequencing.
    case (ctrl_r.state)
      MTC_IDLE: begin
        if (wrConfig && sfrReq.wrData[`MTC_BIT_RUN]) begin // see [RQ8]
          if (sfrReq.wrData[`MTC_BIT_SYNC]) begin
            ctrl_nxt.state = MTC_WAIT_START; // see [RQ7]
          end else begin
            ctrl_nxt.state = MTC_RUN;
          end
        end
      end
      MTC_WAIT_START: begin
        if (wrConfig && !sfrReq.wrData[`MTC_BIT_RUN]) begin
          ctrl_nxt.state = MTC_IDLE;
        end else if (edgePulse) begin
          ctrl_nxt.state      = MTC_STARTING; // see [RQ17]
          ctrl_nxt.startCount = `MTC_SYNC_START_CYCLES - `MTC_CNT_ONE;
        end
      end
      MTC_STARTING: begin
        if (ctrl_r.startCount == `MTC_CNT_ONE) begin
          ctrl_nxt.state      = MTC_RUN; // see [RQ17]
          ctrl_nxt.timerCount = reloadValue;
          ctrl_nxt.deltaCount = `MTC_WORD_ZERO;
        end
        ctrl_nxt.startCount = ctrl_r.startCount - `MTC_CNT_ONE;
      end
      MTC_RUN: begin
        if (wrConfig && !sfrReq.wrData[`MTC_BIT_RUN]) begin // see [RQ8]
          if (sfrReq.wrData[`MTC_BIT_SYNC]) begin
            ctrl_nxt.state = MTC_WAIT_STOP; // see [RQ16]
          end else begin
            ctrl_nxt.state = MTC_IDLE; // see [RQ7]
          end
        end
      end
      MTC_WAIT_STOP: begin
        if (wrConfig && sfrReq.wrData[`MTC_BIT_RUN]) begin
          ctrl_nxt.state = MTC_RUN;
        end else if (edgePulse) begin
          ctrl_nxt.state      = MTC_IDLE; // see [RQ16]
          ctrl_nxt.sleepStore = 1'b1;
        end
      end
      default: begin
        ctrl_nxt.state = MTC_IDLE;
      end
    endcase

    // Status follows the state, so it moves only at the real start or stop.
    ctrl_nxt.running = (ctrl_nxt.state == MTC_RUN) ||
                       (ctrl_nxt.state == MTC_WAIT_STOP); // see [RQ10]
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_r.state                    <= MTC_IDLE;
      ctrl_r.compareEventFlag         <= 1'b0;
      ctrl_r.periodEventFlag          <= 1'b0;
      ctrl_r.overflowCountCompareFlag <= 1'b0;
      ctrl_r.compareByteSelect        <= 1'b0;
      ctrl_r.reservedBit              <= 1'b0;
      ctrl_r.syncSelect               <= `MTC_SYNC_RESET; // see [RQ7]
      ctrl_r.timerCount               <= `MTC_WORD_ZERO;
      ctrl_r.deltaCount               <= `MTC_WORD_ZERO;
      ctrl_r.deltaLow                 <= `MTC_BYTE_ZERO;
      ctrl_r.latchedHigh              <= `MTC_BYTE_ZERO;
      ctrl_r.startCount               <= `MTC_CNT_ZERO;
      ctrl_r.rdData                   <= `MTC_BYTE_ZERO;
      ctrl_r.irqReq                   <= 3'h0;
      ctrl_r.sleepStore               <= 1'b0;
      ctrl_r.running                  <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign sfrRdData        = ctrl_r.rdData;
  assign timerValue       = ctrl_r.timerCount;
  assign timerRunning     = ctrl_r.running;
  assign irqRequest       = ctrl_r.irqReq;
  assign sleepStoreStrobe = ctrl_r.sleepStore;

endmodule // mac_timer_control_regs

/* dv/mtc_assertions.sv */
/*
  Concurrent checks on the ports of the MAC timer control registers.
  Assumes it is bound to mac_timer_control_regs and sees only its ports.
*/
`timescale 1ns/1ps
`include "mtc_regs.svh"
module mtc_assertions
  import mtc_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         reset_n,
  input wire mtc_sfr_req_t sfrReq,
  input wire logic [7:0]   sfrRdData,
  input wire logic [15:0]  timerValue,
  input wire logic         timerRunning,
  input wire logic [2:0]   irqMask,
  input wire logic [2:0]   irqRequest,
  input wire logic         overflowCompareEvent,
  input wire logic         sleepStoreStrobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence cfg_rd;
    sfrReq.rdEn && sfrReq.addr == `MTC_ADDR_CONFIG;
  endsequence
  sequence cfg_wr(logic [1:0] low);
    sfrReq.wrEn && sfrReq.addr == `MTC_ADDR_CONFIG && sfrReq.wrData[1:0] == low
      && !timerRunning;
  endsequence
  sequence delta_wr;
    timerRunning && sfrReq.wrEn && sfrReq.addr == `MTC_ADDR_VALUE_HIGH
      && sfrReq.wrData != 8'h00;
  endsequence

  chk_unused_zero: assert property (cfg_rd |=> !sfrRdData[4])
    else $error("unused config bit read as one");
  chk_status_read: assert property (cfg_rd |=> sfrRdData[0] == $past(timerRunning))
    else $error("run bit read differs from timer state");
  chk_low_read: assert property (sfrReq.rdEn && sfrReq.addr == `MTC_ADDR_VALUE_LOW
    |=> sfrRdData == $past(timerValue[7:0])) else $error("low byte read wrong");
  chk_read_idle: assert property (!sfrReq.rdEn |=> sfrRdData == 8'h00)
    else $error("read data without a read");
  chk_imm_start: assert property (cfg_wr(2'b01) |=> timerRunning)
    else $error("immediate start not taken");
  chk_sync_hold: assert property (cfg_wr(2'b11) |=> !timerRunning [*8])
    else $error("synchronized start took effect at once");
  chk_stop_strobe: assert property (sleepStoreStrobe |-> !timerRunning && $past(timerRunning))
    else $error("sleep store without a stop");
  chk_irq_masked: assert property ((irqRequest & ~$past(irqMask)) == 3'h0)
    else $error("request raised while masked");
  chk_ovf_flag: assert property (overflowCompareEvent ##[1:2] cfg_rd |=> sfrRdData[5])
    else $error("overflow compare flag not set");
  chk_direct_load: assert property (!timerRunning && sfrReq.wrEn
    && sfrReq.addr == `MTC_ADDR_VALUE_LOW |=> timerValue[7:0] == $past(sfrReq.wrData))
    else $error("idle low byte write not loaded");
  chk_delta_pause: assert property (delta_wr |=> ##1 $stable(timerValue) [*4])
    else $error("timer counted during delta pause");
endmodule // mtc_assertions

bind mac_timer_control_regs mtc_assertions u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
  .timerValue(timerValue), .timerRunning(timerRunning), .irqMask(irqMask),
  .irqRequest(irqRequest), .overflowCompareEvent(overflowCompareEvent),
  .sleepStoreStrobe(sleepStoreStrobe));

/* dv/testbench.sv */
/*
  Self-checking bench of the MAC timer control registers.
  Assumes the design package, header and checker are compiled first.
*/
`timescale 1ns/1ps
`include "mtc_regs.svh"
module testbench;
  import mtc_pkg::*;
  logic         core_clk = 1'b0;
  logic         reset_n = 1'b0;
  mtc_sfr_req_t sfrReq = '0;
  logic [7:0]   compareValue = 8'h05;
  logic [15:0]  periodValue = 16'h0010;
  logic         overflowCompareEvent = 1'b0;
  logic [2:0]   irqMask = 3'h0;
  logic [15:0]  reloadValue = 16'h0000;
  logic         slowClk = 1'b0;
  logic [7:0]   sfrRdData;
  logic [15:0]  timerValue;
  logic         timerRunning;
  logic [2:0]   irqRequest;
  logic         sleepStoreStrobe;
  int           miscompares = 0;
  int           num_checks = 0;
  integer       seed = 9912;
  logic [15:0]  expQ[$];
  logic [15:0]  note;
  logic         rdPend = 1'b0;
  logic [7:0]   v0;
  logic [7:0]   v1;
  logic [15:0]  t0;
  int           n;

  always #2.5 core_clk = ~core_clk;
  always #15259 slowClk = ~slowClk;

  mac_timer_control_regs dut (
    .core_clk(core_clk), .reset_n(reset_n), .sfrReq(sfrReq), .compareValue(compareValue),
    .periodValue(periodValue), .overflowCompareEvent(overflowCompareEvent),
    .irqMask(irqMask), .reloadValue(reloadValue), .slowClk(slowClk),
    .sfrRdData(sfrRdData), .timerValue(timerValue), .timerRunning(timerRunning),
    .irqRequest(irqRequest), .sleepStoreStrobe(sleepStoreStrobe));

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    sfrReq <= '{addr: a, wrEn: 1'b1, rdEn: 1'b0, wrData: d};
    @(posedge core_clk);
    sfrReq <= '0;
  endtask

  // The expected byte and a mask of the bits that are compared go in one note.
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
    expQ.push_back({m, e});
    @(posedge core_clk);
    sfrReq <= '{addr: a, wrEn: 1'b0, rdEn: 1'b1, wrData: 8'h00};
    @(posedge core_clk);
    sfrReq <= '0;
  endtask

  always @(posedge core_clk) begin
    rdPend <= sfrReq.rdEn;
    if (rdPend && expQ.size() > 0) begin
      note = expQ.pop_front();
      check("read data", {8'h00, note[7:0]}, {8'h00, sfrRdData & note[15:8]});
    end
  end

  task automatic test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(60000 * 5);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(`MTC_ADDR_CONFIG, `MTC_CONFIG_RESET);
    rd(`MTC_ADDR_VALUE_HIGH, 8'h00);
    rd(8'h55, 8'h00);
    v0 = $random(seed);
    v1 = $random(seed);
    wr(`MTC_ADDR_VALUE_LOW, v0);
    wr(`MTC_ADDR_VALUE_HIGH, v1);
    rd(`MTC_ADDR_VALUE_LOW, v0);
    wr(`MTC_ADDR_VALUE_HIGH, ~v1);
    rd(`MTC_ADDR_VALUE_HIGH, v1);
    rd(`MTC_ADDR_VALUE_LOW, v0);
    rd(`MTC_ADDR_VALUE_HIGH, ~v1);
    wr(`MTC_ADDR_CONFIG, 8'hF8);
    rd(`MTC_ADDR_CONFIG, 8'h08);
    wr(`MTC_ADDR_CONFIG, 8'h02);
    @(posedge core_clk);
    overflowCompareEvent <= 1'b1;
    @(posedge core_clk);
    overflowCompareEvent <= 1'b0;
    rd(`MTC_ADDR_CONFIG, 8'h22);
    check("masked request", 16'h0000, 16'(irqRequest));
    irqMask <= 3'h1;
    repeat (2) @(posedge core_clk);
    check("unmasked request", 16'h0001, 16'(irqRequest));
    wr(`MTC_ADDR_CONFIG, 8'hE2);
    rd(`MTC_ADDR_CONFIG, 8'h22);
    wr(`MTC_ADDR_CONFIG, 8'h02);
    rd(`MTC_ADDR_CONFIG, 8'h02);
    wr(`MTC_ADDR_VALUE_LOW, 8'h00);
    wr(`MTC_ADDR_VALUE_HIGH, 8'h00);
    irqMask <= 3'h7;
    wr(`MTC_ADDR_CONFIG, 8'h09);
    rd(`MTC_ADDR_CONFIG, 8'h01, 8'h01);
    repeat (40) @(posedge core_clk);
    rd(`MTC_ADDR_CONFIG, 8'hC9);
    check("flag requests", 16'h0006, 16'(irqRequest));
    wr(`MTC_ADDR_CONFIG, 8'h01);
    repeat (40) @(posedge core_clk);
    rd(`MTC_ADDR_CONFIG, 8'h41);
    periodValue <= 16'h0000;
    wr(`MTC_ADDR_VALUE_LOW, 8'h00);
    wr(`MTC_ADDR_VALUE_HIGH, 8'h01);
    repeat (4) @(posedge core_clk);
    t0 = timerValue;
    repeat (200) @(posedge core_clk);
    check("paused timer", t0, timerValue);
    repeat (100) @(posedge core_clk);
    check("timer resumed", 16'h0001, 16'(timerValue != t0));
    wr(`MTC_ADDR_CONFIG, 8'h00);
    rd(`MTC_ADDR_CONFIG, 8'h00, 8'h01);
    reloadValue <= 16'($random(seed));
    @(negedge slowClk);
    wr(`MTC_ADDR_CONFIG, 8'h03);
    rd(`MTC_ADDR_CONFIG, 8'h00, 8'h01);
    @(posedge slowClk);
    n = 0;
    while (timerRunning !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    check("start delay", 16'h0001, 16'(n >= 76 && n <= 81));
    check("reloaded value", reloadValue, timerValue);
    @(negedge slowClk);
    wr(`MTC_ADDR_CONFIG, 8'h02);
    rd(`MTC_ADDR_CONFIG, 8'h01, 8'h01);
    n = 0;
    while (sleepStoreStrobe !== 1'b1 && n < 8000) begin
      @(posedge core_clk);
      n++;
    end
    check("stop waits for edge", 16'h0001, 16'(n > 1000 && n < 8000));
    check("stopped on strobe", 16'h0000, 16'(timerRunning));
    test_done();
  end
endmodule // testbench
